//--- verilog/oer_pkg.sv
// Purpose: shared constants for the optical echo/ring station handler
// Assumes: mclk at 40 MHz; line idle level is logic 1 (light off)
// Notes: times are kept in their own unit, cycle counts derived from them
`default_nettype none
package oer_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam logic LINE_IDLE = 1'b1;

	// network kind selection
	localparam logic [1:0] NET_ECHO = 2'h0;
	localparam logic [1:0] NET_NOECHO = 2'h1;
	localparam logic [1:0] NET_RING = 2'h2;

	// idle gap that marks the end of a returning telegram (least time, rounded up)
	localparam int unsigned T_GAP_NS = 2750;
	localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest wait for the echo or ring return (rounded down)
	localparam int unsigned T_HOLD_US = 200;
	localparam int unsigned HOLD_CYC = (T_HOLD_US * 1000) / CLK_PERIOD_NS;
	// low level this long on the ring means a closed loop (least time, rounded up)
	localparam int unsigned T_STUCK_US = 100;
	localparam int unsigned STUCK_CYC = (T_STUCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned CNT_W = 16;

	typedef enum logic [1:0] {
		OER_ST_IDLE = 2'h0,
		OER_ST_TX = 2'h1,
		OER_ST_HOLD = 2'h3,
		OER_ST_BREAK = 2'h2
	} oer_state_e;
endpackage
`default_nettype wire

//--- verilog/oer_run_cnt.sv
// Purpose: counts consecutive enabled cycles in which a condition holds
// Assumes: single clock domain, synchronous condition
// Notes: saturates at LIMIT so hit stays up until the condition drops
`timescale 1ns/1ps
`default_nettype none
module oer_run_cnt #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned LIMIT = 100
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cond,
	output logic hit
);
	logic [WIDTH-1:0] cnt_ff;

	if (LIMIT < 1 || LIMIT >= (64'd1 << WIDTH)) begin : g_bad_limit
		$error("oer_run_cnt: LIMIT does not fit WIDTH");
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (clk_en) begin
			if (!cond)
				cnt_ff <= '0;
			else if (cnt_ff != WIDTH'(LIMIT))
				cnt_ff <= cnt_ff + WIDTH'(1);
		end
	end

	assign hit = (cnt_ff == WIDTH'(LIMIT));
endmodule
`default_nettype wire

//--- verilog/oer_station.sv
// Purpose: station-side signal handling between the data link bit streams and the optical lines
// Assumes: all inputs synchronous to mclk; net_kind and echo_ret_en are static
// Notes: outputs are registered, so every path adds one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module oer_station
	import oer_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = GAP_CYC,
	parameter int unsigned HOLD_CYCLES = HOLD_CYC,
	parameter int unsigned STUCK_CYCLES = STUCK_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] net_kind,
	input wire logic echo_ret_en,
	input wire logic is_master,
	input wire logic dll_tx_en,
	input wire logic dll_txd,
	input wire logic opt_rxd,
	output logic dll_rxd,
	output logic opt_txd,
	output logic opt_ret,
	output logic link_ok,
	output logic ring_open
);
	oer_state_e state_ff, nxt_state;
	logic dll_rxd_ff, nxt_dll_rxd;
	logic opt_txd_ff, nxt_opt_txd;
	logic opt_ret_ff;
	logic link_ok_ff;
	logic echo_seen_ff;
	logic gap_hit, hold_hit, stuck_hit;

	if (GAP_CYCLES < 1 || HOLD_CYCLES <= GAP_CYCLES || STUCK_CYCLES < 1) begin : g_bad_timing
		$error("oer_station: timing parameters out of range");
	end
	if (HOLD_CYCLES >= (64'd1 << CNT_W) || STUCK_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_width
		$error("oer_station: count too wide for counters");
	end

	// ----------------------------------------
	// run counters
	// ----------------------------------------
	oer_run_cnt #(.WIDTH(CNT_W), .LIMIT(GAP_CYCLES)) u_gap (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.cond(opt_rxd == LINE_IDLE),
		.hit(gap_hit)
	);

	oer_run_cnt #(.WIDTH(CNT_W), .LIMIT(HOLD_CYCLES)) u_hold (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.cond(state_ff == OER_ST_HOLD),
		.hit(hold_hit)
	);

	oer_run_cnt #(.WIDTH(CNT_W), .LIMIT(STUCK_CYCLES)) u_stuck (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.cond(opt_rxd != LINE_IDLE),
		.hit(stuck_hit)
	);

	// ----------------------------------------
	// transmit / hold sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			OER_ST_IDLE: begin
				if (dll_tx_en)
					nxt_state = OER_ST_TX;
				else if (net_kind == NET_RING && stuck_hit)
					nxt_state = OER_ST_BREAK;
			end
			OER_ST_TX: begin
				if (!dll_tx_en)
					nxt_state = (net_kind == NET_NOECHO) ? OER_ST_IDLE : OER_ST_HOLD;
			end
			OER_ST_HOLD: begin
				if (dll_tx_en)
					nxt_state = OER_ST_TX;
				else if ((echo_seen_ff && gap_hit) || hold_hit)
					nxt_state = OER_ST_IDLE;
			end
			OER_ST_BREAK: begin
				if (dll_tx_en)
					nxt_state = OER_ST_TX;
				else if (gap_hit)
					nxt_state = OER_ST_IDLE;
			end
			default: nxt_state = OER_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_ff <= OER_ST_IDLE;
		else if (clk_en)
			state_ff <= nxt_state;
	end

	// ----------------------------------------
	// echo detection and link status
	// ----------------------------------------
	// echo may come any time in tx or hold
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			echo_seen_ff <= 1'b0;
		else if (clk_en) begin
			if (state_ff == OER_ST_IDLE || state_ff == OER_ST_BREAK)
				echo_seen_ff <= 1'b0;
			else if (opt_rxd != LINE_IDLE)
				echo_seen_ff <= 1'b1;
		end
	end

	// a missing echo only lowers the status, it never raises an error
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			link_ok_ff <= 1'b0;
		else if (clk_en) begin
			if (net_kind == NET_NOECHO)
				link_ok_ff <= 1'b0;
			else if (state_ff == OER_ST_HOLD && nxt_state != OER_ST_HOLD)
				link_ok_ff <= echo_seen_ff;
		end
	end

	// ----------------------------------------
	// data paths
	// ----------------------------------------
	always_comb begin
		nxt_dll_rxd = LINE_IDLE;
		nxt_opt_txd = LINE_IDLE;
		case (state_ff)
			OER_ST_IDLE: begin
				nxt_dll_rxd = opt_rxd;
				if (net_kind == NET_RING)
					nxt_opt_txd = opt_rxd;
			end
			OER_ST_TX: begin
				nxt_opt_txd = dll_txd;
				if (net_kind == NET_NOECHO && is_master)
					nxt_dll_rxd = dll_txd;
			end
			OER_ST_HOLD: begin
				nxt_dll_rxd = LINE_IDLE;
				nxt_opt_txd = LINE_IDLE;
			end
			OER_ST_BREAK: begin
				nxt_dll_rxd = LINE_IDLE;
				nxt_opt_txd = LINE_IDLE;
			end
			default: begin
				nxt_dll_rxd = LINE_IDLE;
				nxt_opt_txd = LINE_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dll_rxd_ff <= LINE_IDLE;
			opt_txd_ff <= LINE_IDLE;
		end else if (clk_en) begin
			dll_rxd_ff <= nxt_dll_rxd;
			opt_txd_ff <= nxt_opt_txd;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			opt_ret_ff <= LINE_IDLE;
		else if (clk_en)
			opt_ret_ff <= echo_ret_en ? opt_rxd : LINE_IDLE;
	end

	logic ring_open_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ring_open_ff <= 1'b0;
		else if (clk_en)
			ring_open_ff <= (net_kind == NET_RING) && (nxt_state == OER_ST_TX || nxt_state == OER_ST_HOLD);
	end

	assign dll_rxd = dll_rxd_ff;
	assign opt_txd = opt_txd_ff;
	assign opt_ret = opt_ret_ff;
	assign link_ok = link_ok_ff;
	assign ring_open = ring_open_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ret_follows_rx: assert property (clk_en && echo_ret_en |=> opt_ret == $past(opt_rxd))
		else $error("return line does not follow input");
	a_ret_idle_off: assert property (clk_en && !echo_ret_en |=> opt_ret == LINE_IDLE)
		else $error("return line not idle with echo off");
	a_hold_no_rx: assert property (clk_en && state_ff == OER_ST_HOLD |=> dll_rxd == LINE_IDLE)
		else $error("echo leaked to receive stream");
	a_hold_no_tx: assert property (clk_en && state_ff == OER_ST_HOLD |=> opt_txd == LINE_IDLE)
		else $error("echo sent back out");
	a_ring_repeat: assert property (clk_en && state_ff == OER_ST_IDLE && net_kind == NET_RING
		|=> opt_txd == $past(opt_rxd))
		else $error("ring not repeated");
	a_loop_master: assert property (clk_en && state_ff == OER_ST_TX && net_kind == NET_NOECHO && is_master
		|=> dll_rxd == $past(dll_txd))
		else $error("no local loopback");
	a_noecho_link: assert property (clk_en && net_kind == NET_NOECHO |=> !link_ok)
		else $error("link status without echo");
	a_stuck_break: assert property (clk_en && state_ff == OER_ST_IDLE && net_kind == NET_RING
		&& stuck_hit && !dll_tx_en |=> state_ff == OER_ST_BREAK)
		else $error("closed ring not broken");
	a_hold_stays: assert property (clk_en && state_ff == OER_ST_HOLD && !echo_seen_ff && !hold_hit
		&& !dll_tx_en |=> state_ff == OER_ST_HOLD)
		else $error("ring closed before return");
	a_link_echo: assert property (clk_en && state_ff == OER_ST_HOLD && nxt_state == OER_ST_IDLE
		&& net_kind != NET_NOECHO |=> link_ok == $past(echo_seen_ff))
		else $error("link status not from echo");

	c_echo_ok: cover property (state_ff == OER_ST_HOLD && echo_seen_ff ##1 link_ok);
	c_ring_break: cover property (state_ff == OER_ST_BREAK);
	c_hold_tmo: cover property (state_ff == OER_ST_HOLD && hold_hit);
endmodule
`default_nettype wire

//--- dv/oer_net_model.sv
// Purpose: far side of the station: coupler or ring sending the station's light back late
// Assumes: one mclk domain; idle line level is 1 (light off)
// Notes: inj_en lets the bench put foreign traffic or noise on the receive line
`timescale 1ns/1ps
`default_nettype none
module oer_net_model
	import oer_pkg::*;
#(
	parameter int unsigned DLY = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic echo_on,
	input wire logic inj_en,
	input wire logic inj_val,
	input wire logic opt_txd,
	output logic opt_rxd
);
	logic [DLY-1:0] dly_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dly_ff <= {DLY{LINE_IDLE}};
		end else begin
			dly_ff <= {dly_ff[DLY-2:0], opt_txd};
		end
	end
	// echo comes back a round trip late
	assign opt_rxd = inj_en ? inj_val : (echo_on ? dly_ff[DLY-1] : LINE_IDLE);
endmodule
`default_nettype wire

//--- dv/optical_echo_ring_handler_tb.sv
// Purpose: self-checking bench for oer_station against a delayed-echo network model
// Assumes: short counts GAP 20, HOLD 64, STUCK 32
// Notes: outputs are sampled 1 ns after the edge so registered values have landed
`timescale 1ns/1ps
`default_nettype none
module optical_echo_ring_handler_tb;
	import oer_pkg::*;
	// gap longer than a telegram, so idle bits inside an echo cannot end the hold early
	localparam int unsigned GAP = 20;
	localparam int unsigned HOLD = 64;
	localparam int unsigned STUCK = 32;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [1:0] net_kind = NET_RING;
	logic echo_ret_en = 1'b0;
	logic is_master = 1'b0;
	logic dll_tx_en = 1'b0;
	logic dll_txd = 1'b1;
	logic m_echo = 1'b0;
	logic inj_en = 1'b0;
	logic inj_val = 1'b1;
	wire logic opt_rxd;
	logic dll_rxd, opt_txd, opt_ret, link_ok, ring_open;
	int n_fail = 0;
	int n_compared = 0;

	oer_station #(.GAP_CYCLES(GAP), .HOLD_CYCLES(HOLD), .STUCK_CYCLES(STUCK)) oer_station_i (.mclk(mclk),
		.rst_n(rst_n), .clk_en(clk_en), .net_kind(net_kind), .echo_ret_en(echo_ret_en), .is_master(is_master),
		.dll_tx_en(dll_tx_en), .dll_txd(dll_txd), .opt_rxd(opt_rxd), .dll_rxd(dll_rxd), .opt_txd(opt_txd),
		.opt_ret(opt_ret), .link_ok(link_ok), .ring_open(ring_open));
	oer_net_model #(.DLY(8)) oer_net_model_i (.mclk(mclk), .rst_n(rst_n), .echo_on(m_echo), .inj_en(inj_en),
		.inj_val(inj_val), .opt_txd(opt_txd), .opt_rxd(opt_rxd));

	initial begin
		forever #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;
	end

	// ----------------------------------------
	// checking and ending
	// ----------------------------------------
	task automatic chk(input string nm, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask

	// expected return line level
	function automatic logic exp_ret(input logic en, input logic v);
		return en ? v : LINE_IDLE;
	endfunction

	// link status only where an echo can come back
	function automatic logic exp_link(input logic [1:0] kind, input logic ech);
		return ech && kind != NET_NOECHO;
	endfunction

	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// random foreign traffic into an idle ring station
	task automatic rep(input int n);
		logic prv;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			prv = inj_val;
			inj_en <= 1'b1;
			inj_val <= 1'($urandom);
			#1;
			if (i > 0) begin
				chk("opt_txd", opt_txd, prv);
				chk("dll_rxd", dll_rxd, prv);
				chk("opt_ret", opt_ret, exp_ret(echo_ret_en, prv));
			end
		end
		@(posedge mclk);
		inj_en <= 1'b0;
		inj_val <= 1'b1;
	endtask

	// one telegram of 16 bits (a zero, then 15 random), then the hold phase
	task automatic run(input logic [1:0] kind, input logic mst, input logic ech);
		logic prv;
		logic ring;
		ring = (kind == NET_RING);
		@(posedge mclk);
		net_kind <= kind;
		is_master <= mst;
		m_echo <= ech;
		repeat (GAP + 4) @(posedge mclk);
		dll_tx_en <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			prv = dll_txd;
			// a leading zero makes sure the echo is seen
			dll_txd <= (i == 0) ? 1'b0 : 1'($urandom);
			#1;
			if (i == 0) chk("ring_open", ring_open, ring);
			if (i > 0) chk("opt_txd", opt_txd, prv);
			if (kind != NET_NOECHO || !mst) chk("dll_rxd", dll_rxd, LINE_IDLE);
			else chk("dll_rxd", dll_rxd, prv);
		end
		@(posedge mclk);
		prv = dll_txd;
		dll_tx_en <= 1'b0;
		dll_txd <= LINE_IDLE;
		#1;
		chk("opt_txd", opt_txd, prv);
		for (int k = 0; k < HOLD + 16; k++) begin
			@(posedge mclk);
			#1;
			chk("opt_txd", opt_txd, LINE_IDLE);
			chk("dll_rxd", dll_rxd, LINE_IDLE);
			if (k == 4) chk("ring_open", ring_open, ring);
		end
		chk("link_ok", link_ok, exp_link(kind, ech));
		chk("ring_open", ring_open, 1'b0);
	endtask

	initial begin
		void'($urandom(32'h4e7a86d9));
		repeat (2) @(posedge mclk);
		#1;
		chk("opt_txd", opt_txd, LINE_IDLE);
		chk("opt_ret", opt_ret, LINE_IDLE);
		chk("link_ok", link_ok, 1'b0);
		chk("dll_rxd", dll_rxd, LINE_IDLE);
		chk("ring_open", ring_open, 1'b0);
		@(posedge mclk);
		rst_n <= 1'b1;
		echo_ret_en <= 1'b1;
		rep(24);
		echo_ret_en <= 1'b0;
		rep(12);
		run(NET_ECHO, 1'b1, 1'b1);
		run(NET_ECHO, 1'b0, 1'b0);
		run(NET_NOECHO, 1'b1, 1'b0);
		run(NET_NOECHO, 1'b0, 1'b0);
		run(NET_RING, 1'b0, 1'b1);
		// reset in mid-run must drop the link status left by the ring telegram
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		#1;
		chk("link_ok", link_ok, 1'b0);
		chk("ring_open", ring_open, 1'b0);
		chk("opt_txd", opt_txd, LINE_IDLE);
		@(posedge mclk);
		rst_n <= 1'b1;
		// a stuck-low ring must be broken, then repeating resumes
		@(posedge mclk);
		inj_en <= 1'b1;
		inj_val <= 1'b0;
		repeat (STUCK + 4) @(posedge mclk);
		#1;
		chk("opt_txd", opt_txd, LINE_IDLE);
		chk("dll_rxd", dll_rxd, LINE_IDLE);
		@(posedge mclk);
		inj_val <= 1'b1;
		repeat (GAP + 4) @(posedge mclk);
		rep(12);
		end_of_test();
	end

	// far longer than the roughly 730 cycles the sequence needs
	initial begin
		#(5000 * CLK_PERIOD_NS);
		n_fail++;
		end_of_test();
	end
endmodule
`default_nettype wire
